// file: core/irq_flag_pkg.sv
package irq_flag_pkg;

	localparam int ADDR_W    = 8;
	localparam int NUM_BANKS = 4;

	localparam logic [7:0] SERIAL_FLAGS_OFS = 8'h00;
	localparam logic [7:0] TIMER_FLAGS_OFS  = 8'h04;
	localparam logic [7:0] LCG_FLAGS_OFS    = 8'h08;
	localparam logic [7:0] CCP_FLAGS_OFS    = 8'h0C;
	localparam logic [7:0] SERIAL_EN_OFS    = 8'h10;
	localparam logic [7:0] TIMER_EN_OFS     = 8'h14;
	localparam logic [7:0] LCG_EN_OFS       = 8'h18;
	localparam logic [7:0] CCP_EN_OFS       = 8'h1C;
	localparam logic [7:0] IRQ_CTRL_OFS     = 8'h20;
	localparam logic [7:0] EVT_STATUS_OFS   = 8'h24;
	localparam logic [7:0] EVT_ENABLE_OFS   = 8'h28;
	localparam logic [7:0] EVT_CLEAR_OFS    = 8'h2C;

	localparam logic [7:0] SERIAL_IMPL = 8'h3F;
	localparam logic [7:0] SERIAL_WR   = 8'h0F;
	localparam logic [7:0] SERIAL_RO   = 8'h30;
	localparam logic [7:0] TIMER_IMPL  = 8'h3F;
	localparam logic [7:0] LCG_IMPL    = 8'hF7;
	localparam logic [7:0] CCP_IMPL    = 8'h1F;

	localparam int RX_PENDING_BIT   = 5;
	localparam int TX_SPACE_BIT     = 4;
	localparam int BUS_COLL_TWO_BIT = 3;
	localparam int SYNC_TWO_BIT     = 2;
	localparam int BUS_COLL_ONE_BIT = 1;
	localparam int SYNC_ONE_BIT     = 0;
	localparam int GLOBAL_EN_BIT    = 7;
	localparam int PERIPH_EN_BIT    = 6;
	localparam int CELL_LSB         = 4;
	localparam int CCP_LSB          = 0;

	localparam int PERIOD_TIMER_POS [3] = '{1, 3, 5};
	localparam int OVF_TIMER_POS    [3] = '{0, 2, 4};
	localparam int GATE_POS         [3] = '{0, 1, 2};

	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] EN_RESET   = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] EVT_RESET  = 4'h0;

	typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_PWM} capcomp_mode_t;

endpackage

// file: core/flag_bank.sv
`timescale 1ns/1ps
module flag_bank
#(
	parameter int         WIDTH     = 8,
	parameter logic [7:0] IMPL_MASK = 8'hFF,
	parameter logic [7:0] WR_MASK   = 8'hFF,
	parameter logic [7:0] RO_MASK   = 8'h00
)
(
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic      [WIDTH-1:0] flags,
	output logic                  hw_set
);

	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] flags_nxt;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				if (!IMPL_MASK[i])
					flags_nxt[i] = 1'b0;
				else if (RO_MASK[i])
					flags_nxt[i] = set_in[i];
				else if (set_in[i])
					flags_nxt[i] = 1'b1;
				else if (wr_en && WR_MASK[i])
					flags_nxt[i] = wr_data[i];
				else
					flags_nxt[i] = flags_r[i];
			end

			always_ff @(posedge clock)
			begin
				if (rst)
					flags_r[i] <= irq_flag_pkg::FLAG_RESET[i];
				else
					flags_r[i] <= flags_nxt[i];
			end
		end
	endgenerate

	assign flags  = flags_r;
	assign hw_set = |(set_in & IMPL_MASK[WIDTH-1:0] & ~RO_MASK[WIDTH-1:0]);

endmodule

// file: core/event_decode.sv
`timescale 1ns/1ps
module event_decode
(
	input  wire logic                             clock,
	input  wire logic                             rst,
	input  wire logic [2:0]                       timer_overflow,
	input  wire logic [2:0]                       timer_postscale_ovf,
	input  wire logic [2:0]                       timer_period_match,
	input  wire logic [2:0]                       timer_ratio_one,
	input  wire logic [2:0]                       timer_gate_active,
	input  wire logic [3:0]                       logic_cell_event,
	input  wire irq_flag_pkg::capcomp_mode_t [4:0] capcomp_mode_select,
	input  wire logic [4:0]                       capture_event,
	input  wire logic [4:0]                       compare_match,
	input  wire logic [4:0]                       pwm_trailing_edge,
	output logic      [7:0]                       timer_set,
	output logic      [7:0]                       gate_cell_set,
	output logic      [7:0]                       capcomp_set
);

	logic [2:0] gate_prev_r;
	logic [2:0] gate_prev_nxt;

	always_comb
	begin
		gate_prev_nxt = timer_gate_active;
		timer_set     = 8'h00;
		gate_cell_set = 8'h00;
		capcomp_set   = 8'h00;
		for (int t = 0; t < 3; t++)
		begin
			// Match replaces postscaler overflow at 1:1
			timer_set[irq_flag_pkg::PERIOD_TIMER_POS[t]] = timer_ratio_one[t] ?
				timer_period_match[t] : timer_postscale_ovf[t];
			timer_set[irq_flag_pkg::OVF_TIMER_POS[t]] = timer_overflow[t];
			// Gate closing is its falling edge
			gate_cell_set[irq_flag_pkg::GATE_POS[t]] =
				gate_prev_r[t] & ~timer_gate_active[t];
		end
		gate_cell_set[irq_flag_pkg::CELL_LSB +: 4] = logic_cell_event;
		for (int u = 0; u < 5; u++)
		begin
			case (capcomp_mode_select[u])
				irq_flag_pkg::MODE_CAPTURE:
					capcomp_set[irq_flag_pkg::CCP_LSB + u] = capture_event[u];
				irq_flag_pkg::MODE_COMPARE:
					capcomp_set[irq_flag_pkg::CCP_LSB + u] = compare_match[u];
				irq_flag_pkg::MODE_PWM:
					capcomp_set[irq_flag_pkg::CCP_LSB + u] = pwm_trailing_edge[u];
				default:
					capcomp_set[irq_flag_pkg::CCP_LSB + u] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			gate_prev_r <= 3'h0;
		else
			gate_prev_r <= gate_prev_nxt;
	end

endmodule

// file: core/peripheral_irq_flag_bank.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module peripheral_irq_flag_bank
(
	input  wire logic                             clock,
	input  wire logic                             rst,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [7:0]                       paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	input  wire logic                             rx_buffer_nonempty,
	input  wire logic                             tx_buffer_has_space,
	input  wire logic [1:0]                       bus_collision_event,
	input  wire logic [1:0]                       sync_serial_event,
	input  wire logic [2:0]                       timer_overflow,
	input  wire logic [2:0]                       timer_postscale_ovf,
	input  wire logic [2:0]                       timer_period_match,
	input  wire logic [2:0]                       timer_ratio_one,
	input  wire logic [2:0]                       timer_gate_active,
	input  wire logic [3:0]                       logic_cell_event,
	input  wire irq_flag_pkg::capcomp_mode_t [4:0] capcomp_mode_select,
	input  wire logic [4:0]                       capture_event,
	input  wire logic [4:0]                       compare_match,
	input  wire logic [4:0]                       pwm_trailing_edge,
	output logic                                  cpu_irq,
	output logic                                  irq
);

	logic [7:0]  serial_set;
	logic [7:0]  timer_set;
	logic [7:0]  gate_cell_set;
	logic [7:0]  capcomp_set;
	logic [7:0]  serial_flags;
	logic [7:0]  timer_flags;
	logic [7:0]  lcg_flags;
	logic [7:0]  ccp_flags;
	logic [3:0]  hw_set;
	logic [3:0]  flag_wr;
	logic [3:0]  evt_clr;
	logic [3:0]  pending;
	logic        setup;
	logic        wr_acc;
	logic        addr_ok;
	logic [31:0] rd_val;

	logic [7:0]  serial_en_r;
	logic [7:0]  serial_en_nxt;
	logic [7:0]  timer_en_r;
	logic [7:0]  timer_en_nxt;
	logic [7:0]  lcg_en_r;
	logic [7:0]  lcg_en_nxt;
	logic [7:0]  ccp_en_r;
	logic [7:0]  ccp_en_nxt;
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [3:0]  evt_status_r;
	logic [3:0]  evt_status_nxt;
	logic [3:0]  evt_en_r;
	logic [3:0]  evt_en_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        cpu_irq_r;
	logic        cpu_irq_nxt;
	logic        irq_r;
	logic        irq_nxt;

	// Serial port sources; top bits are absent
	always_comb
	begin
		serial_set                                 = 8'h00;
		serial_set[irq_flag_pkg::RX_PENDING_BIT]   = rx_buffer_nonempty;
		serial_set[irq_flag_pkg::TX_SPACE_BIT]     = tx_buffer_has_space;
		serial_set[irq_flag_pkg::BUS_COLL_TWO_BIT] = bus_collision_event[1];
		serial_set[irq_flag_pkg::SYNC_TWO_BIT]     = sync_serial_event[1];
		serial_set[irq_flag_pkg::BUS_COLL_ONE_BIT] = bus_collision_event[0];
		serial_set[irq_flag_pkg::SYNC_ONE_BIT]     = sync_serial_event[0];
	end

	event_decode u_decode
	(
		.clock               (clock),
		.rst                 (rst),
		.timer_overflow      (timer_overflow),
		.timer_postscale_ovf (timer_postscale_ovf),
		.timer_period_match  (timer_period_match),
		.timer_ratio_one     (timer_ratio_one),
		.timer_gate_active   (timer_gate_active),
		.logic_cell_event    (logic_cell_event),
		.capcomp_mode_select (capcomp_mode_select),
		.capture_event       (capture_event),
		.compare_match       (compare_match),
		.pwm_trailing_edge   (pwm_trailing_edge),
		.timer_set           (timer_set),
		.gate_cell_set       (gate_cell_set),
		.capcomp_set         (capcomp_set)
	);

	flag_bank #(.WIDTH(8), .IMPL_MASK(irq_flag_pkg::SERIAL_IMPL),
		.WR_MASK(irq_flag_pkg::SERIAL_WR), .RO_MASK(irq_flag_pkg::SERIAL_RO)) u_serial
	(
		.clock   (clock),
		.rst     (rst),
		.set_in  (serial_set),
		.wr_en   (flag_wr[0]),
		.wr_data (pwdata[7:0]),
		.flags   (serial_flags),
		.hw_set  (hw_set[0])
	);

	flag_bank #(.WIDTH(8), .IMPL_MASK(irq_flag_pkg::TIMER_IMPL),
		.WR_MASK(irq_flag_pkg::TIMER_IMPL), .RO_MASK(8'h00)) u_timer
	(
		.clock   (clock),
		.rst     (rst),
		.set_in  (timer_set),
		.wr_en   (flag_wr[1]),
		.wr_data (pwdata[7:0]),
		.flags   (timer_flags),
		.hw_set  (hw_set[1])
	);

	flag_bank #(.WIDTH(8), .IMPL_MASK(irq_flag_pkg::LCG_IMPL),
		.WR_MASK(irq_flag_pkg::LCG_IMPL), .RO_MASK(8'h00)) u_lcg
	(
		.clock   (clock),
		.rst     (rst),
		.set_in  (gate_cell_set),
		.wr_en   (flag_wr[2]),
		.wr_data (pwdata[7:0]),
		.flags   (lcg_flags),
		.hw_set  (hw_set[2])
	);

	flag_bank #(.WIDTH(8), .IMPL_MASK(irq_flag_pkg::CCP_IMPL),
		.WR_MASK(irq_flag_pkg::CCP_IMPL), .RO_MASK(8'h00)) u_ccp
	(
		.clock   (clock),
		.rst     (rst),
		.set_in  (capcomp_set),
		.wr_en   (flag_wr[3]),
		.wr_data (pwdata[7:0]),
		.flags   (ccp_flags),
		.hw_set  (hw_set[3])
	);

	// Zero-wait slave; read data is latched in the setup cycle
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;

	always_comb
	begin
		rd_val  = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			irq_flag_pkg::SERIAL_FLAGS_OFS: rd_val[7:0] = serial_flags;
			irq_flag_pkg::TIMER_FLAGS_OFS:  rd_val[7:0] = timer_flags;
			irq_flag_pkg::LCG_FLAGS_OFS:    rd_val[7:0] = lcg_flags;
			irq_flag_pkg::CCP_FLAGS_OFS:    rd_val[7:0] = ccp_flags;
			irq_flag_pkg::SERIAL_EN_OFS:    rd_val[7:0] = serial_en_r;
			irq_flag_pkg::TIMER_EN_OFS:     rd_val[7:0] = timer_en_r;
			irq_flag_pkg::LCG_EN_OFS:       rd_val[7:0] = lcg_en_r;
			irq_flag_pkg::CCP_EN_OFS:       rd_val[7:0] = ccp_en_r;
			irq_flag_pkg::IRQ_CTRL_OFS:     rd_val[7:0] = ctrl_r;
			irq_flag_pkg::EVT_STATUS_OFS:   rd_val[3:0] = evt_status_r;
			irq_flag_pkg::EVT_ENABLE_OFS:   rd_val[3:0] = evt_en_r;
			irq_flag_pkg::EVT_CLEAR_OFS:    rd_val      = 32'h0000_0000;
			default:                        addr_ok     = 1'b0;
		endcase
		prdata_nxt = setup ? rd_val : prdata_r;
	end

	always_comb
	begin
		serial_en_nxt = serial_en_r;
		timer_en_nxt  = timer_en_r;
		lcg_en_nxt    = lcg_en_r;
		ccp_en_nxt    = ccp_en_r;
		ctrl_nxt      = ctrl_r;
		evt_en_nxt    = evt_en_r;
		flag_wr       = 4'h0;
		evt_clr       = 4'h0;
		if (wr_acc)
		begin
			case (paddr)
				irq_flag_pkg::SERIAL_FLAGS_OFS: flag_wr[0] = 1'b1;
				irq_flag_pkg::TIMER_FLAGS_OFS:  flag_wr[1] = 1'b1;
				irq_flag_pkg::LCG_FLAGS_OFS:    flag_wr[2] = 1'b1;
				irq_flag_pkg::CCP_FLAGS_OFS:    flag_wr[3] = 1'b1;
				irq_flag_pkg::SERIAL_EN_OFS:
					serial_en_nxt = pwdata[7:0] & irq_flag_pkg::SERIAL_IMPL;
				irq_flag_pkg::TIMER_EN_OFS:
					timer_en_nxt = pwdata[7:0] & irq_flag_pkg::TIMER_IMPL;
				irq_flag_pkg::LCG_EN_OFS:
					lcg_en_nxt = pwdata[7:0] & irq_flag_pkg::LCG_IMPL;
				irq_flag_pkg::CCP_EN_OFS:
					ccp_en_nxt = pwdata[7:0] & irq_flag_pkg::CCP_IMPL;
				irq_flag_pkg::IRQ_CTRL_OFS:
				begin
					ctrl_nxt                             = 8'h00;
					ctrl_nxt[irq_flag_pkg::GLOBAL_EN_BIT] = pwdata[irq_flag_pkg::GLOBAL_EN_BIT];
					ctrl_nxt[irq_flag_pkg::PERIPH_EN_BIT] = pwdata[irq_flag_pkg::PERIPH_EN_BIT];
				end
				irq_flag_pkg::EVT_ENABLE_OFS:   evt_en_nxt = pwdata[3:0];
				irq_flag_pkg::EVT_CLEAR_OFS:    evt_clr    = pwdata[3:0];
				default:                        flag_wr    = 4'h0;
			endcase
		end
		// New hardware set beats a same-cycle clear
		evt_status_nxt = (evt_status_r & ~evt_clr) | hw_set;
		pending[0]     = |(serial_flags & serial_en_r);
		pending[1]     = |(timer_flags & timer_en_r);
		pending[2]     = |(lcg_flags & lcg_en_r);
		pending[3]     = |(ccp_flags & ccp_en_r);
		cpu_irq_nxt    = ctrl_r[irq_flag_pkg::GLOBAL_EN_BIT] &
			ctrl_r[irq_flag_pkg::PERIPH_EN_BIT] & (|pending);
		irq_nxt        = |(evt_status_r & evt_en_r);
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			serial_en_r  <= irq_flag_pkg::EN_RESET;
			timer_en_r   <= irq_flag_pkg::EN_RESET;
			lcg_en_r     <= irq_flag_pkg::EN_RESET;
			ccp_en_r     <= irq_flag_pkg::EN_RESET;
			ctrl_r       <= irq_flag_pkg::CTRL_RESET;
			evt_status_r <= irq_flag_pkg::EVT_RESET;
			evt_en_r     <= irq_flag_pkg::EVT_RESET;
			prdata_r     <= 32'h0000_0000;
			cpu_irq_r    <= 1'b0;
			irq_r        <= 1'b0;
		end
		else
		begin
			serial_en_r  <= serial_en_nxt;
			timer_en_r   <= timer_en_nxt;
			lcg_en_r     <= lcg_en_nxt;
			ccp_en_r     <= ccp_en_nxt;
			ctrl_r       <= ctrl_nxt;
			evt_status_r <= evt_status_nxt;
			evt_en_r     <= evt_en_nxt;
			prdata_r     <= prdata_nxt;
			cpu_irq_r    <= cpu_irq_nxt;
			irq_r        <= irq_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign cpu_irq = cpu_irq_r;
	assign irq     = irq_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Clearing write to timer bit 2 with no competing overflow
	sequence s_timer_clear_write;
		wr_acc && paddr == irq_flag_pkg::TIMER_FLAGS_OFS && !pwdata[2] && !timer_overflow[1];
	endsequence

	sequence s_gate_closes;
		timer_gate_active[0] ##1 !timer_gate_active[0];
	endsequence

	chk_reserved_zero: assert property (
		serial_flags[7:6] == 2'b00 && timer_flags[7:6] == 2'b00 &&
		lcg_flags[3] == 1'b0 && ccp_flags[7:5] == 3'b000)
		else $error("unimplemented flag bit reads one");

	chk_ovf_sets: assert property (
		timer_overflow[1] && !timer_en_r[2] |=> timer_flags[2])
		else $error("timer overflow flag not set");

	chk_enable_free: assert property (
		logic_cell_event[0] && !ctrl_r[irq_flag_pkg::GLOBAL_EN_BIT] |=> lcg_flags[4])
		else $error("flag set depends on enables");

	chk_period_select: assert property (
		!timer_ratio_one[0] && timer_period_match[0] && !timer_postscale_ovf[0] &&
		!timer_flags[1] && !(wr_acc && paddr == irq_flag_pkg::TIMER_FLAGS_OFS)
		|=> !timer_flags[1])
		else $error("period match flagged without 1:1 ratio");

	chk_flag_holds: assert property (
		timer_flags[2] && !(wr_acc && paddr == irq_flag_pkg::TIMER_FLAGS_OFS)
		|=> timer_flags[2])
		else $error("timer flag dropped without software write");

	chk_clear_works: assert property (
		s_timer_clear_write |=> !timer_flags[2])
		else $error("timer flag not cleared by software write");

	chk_gate_close: assert property (
		s_gate_closes |=> lcg_flags[0])
		else $error("gate close not flagged");

	chk_pwm_mode: assert property (
		capcomp_mode_select[0] == irq_flag_pkg::MODE_PWM && pwm_trailing_edge[0]
		|=> ccp_flags[0])
		else $error("pwm trailing edge not flagged");

	chk_cpu_gate: assert property (
		cpu_irq |-> $past(ctrl_r[irq_flag_pkg::GLOBAL_EN_BIT]) &&
		$past(ctrl_r[irq_flag_pkg::PERIPH_EN_BIT]))
		else $error("cpu interrupt without global and peripheral enable");

	chk_rx_mirror: assert property (
		##1 serial_flags[irq_flag_pkg::RX_PENDING_BIT] == $past(rx_buffer_nonempty))
		else $error("receive flag does not follow buffer");

	chk_collision_flag: assert property (
		bus_collision_event[1] |=> serial_flags[irq_flag_pkg::BUS_COLL_TWO_BIT] ##1
		(serial_flags[irq_flag_pkg::BUS_COLL_TWO_BIT] ||
		$past(wr_acc && paddr == irq_flag_pkg::SERIAL_FLAGS_OFS)))
		else $error("collision flag not held");

endmodule

// file: verification/event_source_model.sv
`timescale 1ns/1ps
module event_source_model
(
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [3:0] kind,
	input  wire logic [2:0] idx,
	output logic      [1:0] bus_collision_event,
	output logic      [1:0] sync_serial_event,
	output logic      [2:0] timer_overflow,
	output logic      [2:0] timer_postscale_ovf,
	output logic      [2:0] timer_period_match,
	output logic      [3:0] logic_cell_event,
	output logic      [4:0] capture_event,
	output logic      [4:0] compare_match,
	output logic      [4:0] pwm_trailing_edge
);
	logic [4:0] one_hot;

	assign one_hot = 5'h01 << idx;

	// One-cycle pulse on the chosen source, all others idle low
	always_ff @(posedge clock)
	begin
		bus_collision_event <= (go && kind == 4'h0) ? one_hot[1:0] : 2'h0;
		sync_serial_event   <= (go && kind == 4'h1) ? one_hot[1:0] : 2'h0;
		timer_overflow      <= (go && kind == 4'h2) ? one_hot[2:0] : 3'h0;
		timer_postscale_ovf <= (go && kind == 4'h3) ? one_hot[2:0] : 3'h0;
		timer_period_match  <= (go && kind == 4'h4) ? one_hot[2:0] : 3'h0;
		logic_cell_event    <= (go && kind == 4'h5) ? one_hot[3:0] : 4'h0;
		capture_event       <= (go && kind == 4'h6) ? one_hot : 5'h00;
		compare_match       <= (go && kind == 4'h7) ? one_hot : 5'h00;
		pwm_trailing_edge   <= (go && kind == 4'h8) ? one_hot : 5'h00;
	end
endmodule

// file: verification/peripheral_irq_flag_bank_bench.sv
`timescale 1ns/1ps
module peripheral_irq_flag_bank_bench;
	logic                              clock;
	logic                              rst;
	logic                              psel;
	logic                              penable;
	logic                              pwrite;
	logic [7:0]                        paddr;
	logic [31:0]                       pwdata;
	logic [31:0]                       prdata;
	logic                              pready;
	logic                              pslverr;
	logic                              rx_buffer_nonempty;
	logic                              tx_buffer_has_space;
	logic [1:0]                        bus_collision_event;
	logic [1:0]                        sync_serial_event;
	logic [2:0]                        timer_overflow;
	logic [2:0]                        timer_postscale_ovf;
	logic [2:0]                        timer_period_match;
	logic [2:0]                        timer_ratio_one;
	logic [2:0]                        timer_gate_active;
	logic [3:0]                        logic_cell_event;
	irq_flag_pkg::capcomp_mode_t [4:0] capcomp_mode_select;
	logic [4:0]                        capture_event;
	logic [4:0]                        compare_match;
	logic [4:0]                        pwm_trailing_edge;
	logic                              cpu_irq;
	logic                              irq;
	logic                              go;
	logic [3:0]                        kind;
	logic [2:0]                        idx;
	int                                num_errors;
	int                                samples_checked;
	int                                cycles;

	peripheral_irq_flag_bank u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_buffer_nonempty, .tx_buffer_has_space,
		.bus_collision_event, .sync_serial_event, .timer_overflow, .timer_postscale_ovf,
		.timer_period_match, .timer_ratio_one, .timer_gate_active, .logic_cell_event,
		.capcomp_mode_select, .capture_event, .compare_match, .pwm_trailing_edge,
		.cpu_irq, .irq);

	event_source_model u_src (.clock, .go, .kind, .idx, .bus_collision_event,
		.sync_serial_event, .timer_overflow, .timer_postscale_ovf, .timer_period_match,
		.logic_cell_event, .capture_event, .compare_match, .pwm_trailing_edge);

	always #50 clock = ~clock;

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			num_errors++;
			$display("wrong value at %0t ns: saw %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
		begin
			@(posedge clock);
		end
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic err_want);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, want);
		chk(32'(e), 32'(err_want));
	endtask

	task automatic fire(input logic [3:0] k, input logic [2:0] i);
		@(posedge clock);
		go   <= 1'b1;
		kind <= k;
		idx  <= i;
		@(posedge clock);
		go <= 1'b0;
		tick(2);
	endtask

	task automatic fire_all(input logic [3:0] k, input int n);
		for (int i = 0; i < n; i++)
			fire(k, 3'(i));
	endtask

	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, go, kind, idx} = '0;
		{rx_buffer_nonempty, tx_buffer_has_space, timer_ratio_one, timer_gate_active} = '0;
		capcomp_mode_select = '{default: irq_flag_pkg::MODE_CAPTURE};
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		tick(6);
		rst <= 1'b0;
		for (int o = 0; o <= 8'h2C; o += 4)
			rd(8'(o), 32'h0, 1'b0);
		wr(irq_flag_pkg::EVT_STATUS_OFS, 32'h0F);
		rd(irq_flag_pkg::EVT_STATUS_OFS, 32'h0, 1'b0);
		wr(8'h30, 32'hFF);
		rd(8'h30, 32'h0, 1'b1);
		chk(32'(pready), 32'h1);
		$display("test reset_map done");
		fire_all(4'h2, 3);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h15, 1'b0);
		fire_all(4'h4, 3);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h15, 1'b0);
		fire_all(4'h3, 3);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h3F, 1'b0);
		wr(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h0);
		timer_ratio_one <= 3'h7;
		fire_all(4'h4, 3);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h2A, 1'b0);
		wr(irq_flag_pkg::TIMER_FLAGS_OFS, 32'hFF);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h3F, 1'b0);
		wr(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h3E);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h3E, 1'b0);
		wr(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h0);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h0, 1'b0);
		$display("test timers done");
		@(posedge clock);
		timer_gate_active <= 3'h7;
		tick(2);
		timer_gate_active <= 3'h0;
		tick(2);
		rd(irq_flag_pkg::LCG_FLAGS_OFS, 32'h07, 1'b0);
		fire_all(4'h5, 4);
		rd(irq_flag_pkg::LCG_FLAGS_OFS, 32'hF7, 1'b0);
		wr(irq_flag_pkg::LCG_FLAGS_OFS, 32'h0);
		$display("test gates_cells done");
		for (int m = 0; m < 4; m++)
		begin
			for (int u = 0; u < 5; u++)
				capcomp_mode_select[u] <= irq_flag_pkg::capcomp_mode_t'(m);
			for (int k = 0; k < 3; k++)
				if (k != m)
					fire_all(4'(6 + k), 5);
			rd(irq_flag_pkg::CCP_FLAGS_OFS, 32'h0, 1'b0);
			fire_all(4'(6 + m), 5);
			rd(irq_flag_pkg::CCP_FLAGS_OFS, (m < 3) ? 32'h1F : 32'h0, 1'b0);
			wr(irq_flag_pkg::CCP_FLAGS_OFS, 32'h0);
		end
		$display("test capcomp done");
		fire_all(4'h0, 2);
		fire_all(4'h1, 2);
		rd(irq_flag_pkg::SERIAL_FLAGS_OFS, 32'h0F, 1'b0);
		rx_buffer_nonempty <= 1'b1;
		tx_buffer_has_space <= 1'b1;
		wr(irq_flag_pkg::SERIAL_FLAGS_OFS, 32'h0);
		rd(irq_flag_pkg::SERIAL_FLAGS_OFS, 32'h30, 1'b0);
		rx_buffer_nonempty <= 1'b0;
		tick(2);
		rd(irq_flag_pkg::SERIAL_FLAGS_OFS, 32'h10, 1'b0);
		tx_buffer_has_space <= 1'b0;
		tick(2);
		rd(irq_flag_pkg::SERIAL_FLAGS_OFS, 32'h0, 1'b0);
		rd(irq_flag_pkg::EVT_STATUS_OFS, 32'h0F, 1'b0);
		wr(irq_flag_pkg::EVT_CLEAR_OFS, 32'h0F);
		rd(irq_flag_pkg::EVT_STATUS_OFS, 32'h0, 1'b0);
		$display("test serial done");
		wr(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h0);
		wr(irq_flag_pkg::TIMER_EN_OFS, 32'h01);
		wr(irq_flag_pkg::IRQ_CTRL_OFS, 32'h40);
		fire(4'h2, 3'h0);
		tick(2);
		chk(32'(cpu_irq), 32'h0);
		wr(irq_flag_pkg::IRQ_CTRL_OFS, 32'h80);
		tick(2);
		chk(32'(cpu_irq), 32'h0);
		wr(irq_flag_pkg::IRQ_CTRL_OFS, 32'hC0);
		tick(2);
		chk(32'(cpu_irq), 32'h1);
		wr(irq_flag_pkg::TIMER_EN_OFS, 32'h0);
		tick(2);
		chk(32'(cpu_irq), 32'h0);
		wr(irq_flag_pkg::EVT_ENABLE_OFS, 32'h04);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(irq_flag_pkg::EVT_ENABLE_OFS, 32'h02);
		tick(2);
		chk(32'(irq), 32'h1);
		wr(irq_flag_pkg::EVT_CLEAR_OFS, 32'h02);
		tick(2);
		chk(32'(irq), 32'h0);
		rd(irq_flag_pkg::TIMER_FLAGS_OFS, 32'h01, 1'b0);
		$display("test interrupts done");
		tally_and_finish();
	end
endmodule
